// File: verilog/crcscn_pkg.sv
// Constants, register map and types shared by the CRC scanner register block
`default_nettype none
package crcscn_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets on the AXI4-Lite slave
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_ACC_LOW = 8'h00;
   localparam logic [7:0] OFF_SHIFT_HIGH = 8'h04;
   localparam logic [7:0] OFF_SHIFT_LOW = 8'h08;
   localparam logic [7:0] OFF_TAPS_HIGH = 8'h0c;
   localparam logic [7:0] OFF_TAPS_LOW = 8'h10;
   localparam logic [7:0] OFF_CTL = 8'h14;
   localparam logic [7:0] OFF_CUR_HIGH = 8'h18;
   localparam logic [7:0] OFF_CUR_LOW = 8'h1c;
   localparam logic [7:0] OFF_END_HIGH = 8'h20;
   localparam logic [7:0] OFF_END_LOW = 8'h24;
   localparam logic [7:0] OFF_TRIG = 8'h28;

   // ---------------------------------------------------------------
   // Scanner control field positions
   // ---------------------------------------------------------------
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_GO_BIT = 6;
   localparam int CTL_BUSY_BIT = 5;
   localparam int CTL_INVALID_BIT = 4;
   localparam int CTL_INTERRUPT_MANAGE_BIT_BIT = 3;
   localparam int CTL_MODE_LSB = 0;

   // ---------------------------------------------------------------
   // Reset values and fixed figures
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_ADDR = 16'h0000;
   localparam logic [14:0] RST_TAPS = 15'h0000;
   localparam logic [3:0] RST_SCAN_TRIGGER_SELECT = 4'h0;
   localparam logic [3:0] SCAN_TRIGGER_SELECT_MAX = 4'h9;
   localparam int TRIG_SRC_N = 10;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ---------------------------------------------------------------
   // Access modes and fetch states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_CONCURRENT = 2'b00,
      MODE_BURST = 2'b01,
      MODE_PEEK = 2'b10,
      MODE_TRIGGERED = 2'b11
   } crcscn_mode_type;

   typedef enum logic {
      FS_IDLE,
      FS_FETCH
   } crcscn_fetch_state_type;
endpackage
`default_nettype wire

// File: verilog/crcscn_fetch.sv
// Flash fetch engine: one program flash read per start, word handed to the CRC engine
`timescale 1ns/1ps
`default_nettype none
module crcscn_fetch
   import crcscn_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_start,
   input wire logic [15:0] i_addr,
   output logic o_flash_rd_req,
   output logic [15:0] o_flash_addr,
   input wire logic i_flash_rd_valid,
   input wire logic [DATA_W-1:0] i_flash_rd_data,
   output logic [DATA_W-1:0] o_word,
   output logic o_word_valid,
   output logic o_in_cycle
);
   // ---------------------------------------------------------------
   // Fetch sequencer
   // ---------------------------------------------------------------
   crcscn_fetch_state_type state_ff;
   logic [15:0] addr_ff;
   logic [DATA_W-1:0] word_ff;
   logic word_valid_ff;

   // State: dropping enable aborts any cycle and returns to idle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= FS_IDLE;
      end else if (!i_enable) begin
         state_ff <= FS_IDLE; // [RL4]
      end else begin
         case (state_ff)
            FS_IDLE: if (i_start) state_ff <= FS_FETCH;
            FS_FETCH: if (i_flash_rd_valid) state_ff <= FS_IDLE;
            default: state_ff <= FS_IDLE;
         endcase
      end
   end

   // Address of the word in flight, caught when the cycle opens
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_ff <= RST_ADDR;
      end else if (state_ff == FS_IDLE && i_start) begin
         addr_ff <= i_addr;
      end
   end

   // Word and its one-cycle strobe toward the CRC engine
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         word_ff <= '0;
         word_valid_ff <= 1'b0;
      end else begin
         word_valid_ff <= i_enable && state_ff == FS_FETCH && i_flash_rd_valid; // [RL6]
         if (state_ff == FS_FETCH && i_flash_rd_valid) begin
            word_ff <= i_flash_rd_data;
         end
      end
   end

   assign o_flash_rd_req = (state_ff == FS_FETCH);
   assign o_flash_addr = addr_ff;
   assign o_word = word_ff;
   assign o_word_valid = word_valid_ff;
   assign o_in_cycle = (state_ff == FS_FETCH);
endmodule // crcscn_fetch
`default_nettype wire

// File: verilog/crcscn_regs.sv
// CRC accumulator, shifter, taps and memory scanner registers behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1: Accumulator low byte write goes onto CRC write bus; reads show live value.
// RL2: Shifter shown as two read-only bytes, reset zero, writes ignored.
// RL3: Tap-enable bits 15 to 1 writable; low byte bit 0 reads one.
// RL4: Enable clear stops scanner and resets its state machines.
// RL5: Enable clear leaves addresses, mode and other contents alone.
// RL6: With go set, each CRC ready yields one flash read handed to CRC.
// RL7: Hardware clears go once current exceeds end and no cycle runs.
// RL8: Interrupt management masks go during interrupts without clearing it.
// RL9: Busy shows while flash is read or CRC signals ready.
// RL10: Invalid shows when current address is beyond implemented flash.
// RL11: Burst stalls CPU; interrupt management picks masking or delayed interrupts.
// RL12: Concurrent and triggered: masking with management set, else no effect.
// RL13: Mode codes concurrent, burst, peek, triggered; peek ignores management bit.
// RL14: Current address 16 bits in two bytes, reset zero, increments per fetch.
// RL15: Writes to current address bytes ignored while go set.
// RL16: Software should touch current address only while go is clear.
// RL17: End address 16 bits, reset zero, writes ignored while go set.
// RL18: Triggered mode selects one of ten event sources; codes above nine reserved.
// RL19: Final fetch happens at the end address before passing it.
// RL20: Each byte of wide registers read on its own, no latching.
module crcscn_regs
   import crcscn_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter logic [16:0] FLASH_WORDS = 17'h04000
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic [15:0] i_crc_acc,
   input wire logic [15:0] i_crc_shift,
   input wire logic i_crc_ready,
   output logic o_acc_wr_en,
   output logic [7:0] o_acc_wr_data,
   output logic [15:0] o_poly_taps,
   output logic [DATA_W-1:0] o_scan_word,
   output logic o_scan_word_valid,
   output logic o_flash_rd_req,
   output logic [15:0] o_flash_addr,
   input wire logic i_flash_rd_valid,
   input wire logic [DATA_W-1:0] i_flash_rd_data,
   input wire logic i_irq_active,
   input wire logic i_peek_slot,
   input wire logic [TRIG_SRC_N-1:0] i_trig_src,
   output logic o_cpu_stall
);
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      reg_hit = (a == off);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'b00) && (a <= OFF_TRIG);
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff, wstrb0_ff;
   logic [7:0] awaddr_ff;
   logic [7:0] wdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_fire, wr_lane, ar_fire;
   logic acc_wr_en_ff;
   logic [7:0] acc_wr_data_ff;
   logic [15:1] taps_ff;
   logic en_ff, go_ff, interrupt_manage_bit_ff;
   crcscn_mode_type mode_ff;
   logic [15:0] cur_addr_ff, end_addr_ff;
   logic [3:0] scan_trigger_select_ff;
   logic trig_prev_ff, trig_pend_ff, trig_sel;
   logic go_eff, permit, start, in_cycle, word_valid;
   logic busy, invalid, past_end, go_hw_clear;
   logic [7:0] ctl_byte;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign o_awready = !aw_held_ff && !bvalid_ff;
   assign o_wready = !w_held_ff && !bvalid_ff;
   assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_lane = wr_fire && wstrb0_ff;

   // Address and data are caught separately, in either order
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awaddr_ff <= RST_BYTE;
         wdata_ff <= RST_BYTE;
         wstrb0_ff <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= i_awaddr;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= i_wdata[7:0];
            wstrb0_ff <= i_wstrb[0];
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end
      end
   end

   // Write response, error for an unmapped address
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= is_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   assign o_bvalid = bvalid_ff;
   assign o_bresp = bresp_ff;

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign o_arready = !rvalid_ff;
   assign ar_fire = i_arvalid && o_arready;
   assign ctl_byte = {en_ff, go_ff, busy, invalid, interrupt_manage_bit_ff, 1'b0, mode_ff};

   // Read mux; wide values give each byte live, nothing latched
   always_comb begin
      nxt_rdata = 32'h00000000;
      case (i_araddr)
         OFF_ACC_LOW: nxt_rdata[7:0] = i_crc_acc[7:0]; // [RL1]
         OFF_SHIFT_HIGH: nxt_rdata[7:0] = i_crc_shift[15:8]; // [RL2] [RL20]
         OFF_SHIFT_LOW: nxt_rdata[7:0] = i_crc_shift[7:0]; // [RL2]
         OFF_TAPS_HIGH: nxt_rdata[7:0] = taps_ff[15:8];
         OFF_TAPS_LOW: nxt_rdata[7:0] = {taps_ff[7:1], 1'b1}; // [RL3]
         OFF_CTL: nxt_rdata[7:0] = ctl_byte;
         OFF_CUR_HIGH: nxt_rdata[7:0] = cur_addr_ff[15:8]; // [RL20]
         OFF_CUR_LOW: nxt_rdata[7:0] = cur_addr_ff[7:0];
         OFF_END_HIGH: nxt_rdata[7:0] = end_addr_ff[15:8];
         OFF_END_LOW: nxt_rdata[7:0] = end_addr_ff[7:0];
         OFF_TRIG: nxt_rdata[7:0] = {4'h0, scan_trigger_select_ff};
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   // Read data and response, held until taken
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign o_rvalid = rvalid_ff;
   assign o_rdata = rdata_ff;
   assign o_rresp = rresp_ff;

   // ---------------------------------------------------------------
   // CRC side registers
   // ---------------------------------------------------------------
   // Accumulator low byte write is a one-cycle strobe on the CRC write bus
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acc_wr_en_ff <= 1'b0;
         acc_wr_data_ff <= RST_BYTE;
      end else begin
         acc_wr_en_ff <= wr_lane && reg_hit(awaddr_ff, OFF_ACC_LOW); // [RL1]
         if (wr_lane && reg_hit(awaddr_ff, OFF_ACC_LOW)) begin
            acc_wr_data_ff <= wdata_ff;
         end
      end
   end

   // Polynomial tap enables; bit 0 has no storage
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         taps_ff <= RST_TAPS;
      end else begin
         if (wr_lane && reg_hit(awaddr_ff, OFF_TAPS_HIGH)) taps_ff[15:8] <= wdata_ff; // [RL3]
         if (wr_lane && reg_hit(awaddr_ff, OFF_TAPS_LOW)) taps_ff[7:1] <= wdata_ff[7:1];
      end
   end

   assign o_acc_wr_en = acc_wr_en_ff;
   assign o_acc_wr_data = acc_wr_data_ff;
   assign o_poly_taps = {taps_ff, 1'b1};

   // ---------------------------------------------------------------
   // Scanner control
   // ---------------------------------------------------------------
   assign past_end = cur_addr_ff > end_addr_ff;
   assign invalid = {1'b0, cur_addr_ff} >= FLASH_WORDS; // [RL10]
   assign go_hw_clear = en_ff && go_ff && past_end && !in_cycle; // [RL7]

   // Enable, management bit and mode; enable clear touches nothing else
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_ff <= 1'b0;
         interrupt_manage_bit_ff <= 1'b0;
         mode_ff <= MODE_CONCURRENT;
      end else if (wr_lane && reg_hit(awaddr_ff, OFF_CTL)) begin
         en_ff <= wdata_ff[CTL_EN_BIT]; // [RL5]
         interrupt_manage_bit_ff <= wdata_ff[CTL_INTERRUPT_MANAGE_BIT_BIT];
         mode_ff <= crcscn_mode_type'(wdata_ff[CTL_MODE_LSB +: 2]); // [RL13]
      end
   end

   // Go: software write wins over the hardware clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         go_ff <= 1'b0;
      end else if (wr_lane && reg_hit(awaddr_ff, OFF_CTL)) begin
         go_ff <= wdata_ff[CTL_GO_BIT];
      end else if (go_hw_clear) begin
         go_ff <= 1'b0; // [RL7]
      end
   end

   // Current address: fetch increment first, writes only while go clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cur_addr_ff <= RST_ADDR;
      end else if (word_valid) begin
         cur_addr_ff <= cur_addr_ff + 16'h0001; // [RL14]
      end else if (!go_ff) begin
         if (wr_lane && reg_hit(awaddr_ff, OFF_CUR_HIGH)) cur_addr_ff[15:8] <= wdata_ff; // [RL15]
         if (wr_lane && reg_hit(awaddr_ff, OFF_CUR_LOW)) cur_addr_ff[7:0] <= wdata_ff;
      end
   end

   // End address and trigger select, end address locked while go set
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         end_addr_ff <= RST_ADDR;
         scan_trigger_select_ff <= RST_SCAN_TRIGGER_SELECT;
      end else begin
         if (!go_ff) begin
            if (wr_lane && reg_hit(awaddr_ff, OFF_END_HIGH)) end_addr_ff[15:8] <= wdata_ff; // [RL17]
            if (wr_lane && reg_hit(awaddr_ff, OFF_END_LOW)) end_addr_ff[7:0] <= wdata_ff;
         end
         if (wr_lane && reg_hit(awaddr_ff, OFF_TRIG)) scan_trigger_select_ff <= wdata_ff[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Trigger capture for triggered mode
   // ---------------------------------------------------------------
   assign trig_sel = (scan_trigger_select_ff <= SCAN_TRIGGER_SELECT_MAX) ? i_trig_src[scan_trigger_select_ff] : 1'b0; // [RL18]

   // Rising edge of the chosen source arms one fetch; arming wins over use
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         trig_prev_ff <= 1'b0;
         trig_pend_ff <= 1'b0;
      end else begin
         trig_prev_ff <= trig_sel;
         if (!en_ff) begin
            trig_pend_ff <= 1'b0;
         end else if (trig_sel && !trig_prev_ff) begin
            trig_pend_ff <= 1'b1; // [RL18]
         end else if (start) begin
            trig_pend_ff <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Access qualification per mode
   // ---------------------------------------------------------------
   // Go seen as zero during interrupts when managed, never in peek mode
   assign go_eff = en_ff && go_ff
      && !(interrupt_manage_bit_ff && i_irq_active && mode_ff != MODE_PEEK); // [RL8] [RL12] [RL13]

   always_comb begin
      case (mode_ff)
         MODE_CONCURRENT: permit = 1'b1; // [RL12]
         MODE_BURST: permit = 1'b1; // [RL11]
         MODE_PEEK: permit = i_peek_slot; // [RL13]
         MODE_TRIGGERED: permit = trig_pend_ff; // [RL12]
         default: permit = 1'b0;
      endcase
   end

   // Last fetch is at the end address itself, then the range is passed
   assign start = go_eff && i_crc_ready && permit && !in_cycle && !word_valid
      && !past_end && !invalid; // [RL6] [RL19]

   // Burst holds the CPU; unmanaged interrupts wait behind the burst
   assign o_cpu_stall = en_ff && go_ff && mode_ff == MODE_BURST
      && !(interrupt_manage_bit_ff && i_irq_active); // [RL11]

   assign busy = in_cycle || (en_ff && i_crc_ready); // [RL9]

   // ---------------------------------------------------------------
   // Flash fetch engine
   // ---------------------------------------------------------------
   crcscn_fetch #(
      .DATA_W(DATA_W)
   ) u_fetch (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_enable(en_ff),
      .i_start(start),
      .i_addr(cur_addr_ff),
      .o_flash_rd_req(o_flash_rd_req),
      .o_flash_addr(o_flash_addr),
      .i_flash_rd_valid(i_flash_rd_valid),
      .i_flash_rd_data(i_flash_rd_data),
      .o_word(o_scan_word),
      .o_word_valid(word_valid),
      .o_in_cycle(in_cycle)
   );

   assign o_scan_word_valid = word_valid;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_acc_write_route: assert property ( // [RL1]
      wr_lane && reg_hit(awaddr_ff, OFF_ACC_LOW)
      |=> o_acc_wr_en && o_acc_wr_data == $past(wdata_ff) ##1 !o_acc_wr_en)
      else $error("accumulator write not routed");

   a_shift_read_live: assert property ( // [RL2]
      ar_fire && i_araddr == OFF_SHIFT_HIGH
      |=> o_rvalid && o_rdata == {24'h000000, $past(i_crc_shift[15:8])})
      else $error("shifter high byte read wrong");

   a_tap_bit_zero: assert property ( // [RL3]
      ar_fire && i_araddr == OFF_TAPS_LOW |=> o_rdata[0] && o_rdata[31:8] == 24'h000000)
      else $error("tap low bit 0 not one");

   a_disable_stops: assert property ( // [RL4]
      !en_ff |=> !o_flash_rd_req && !o_scan_word_valid)
      else $error("scanner active while disabled");

   a_disable_keeps: assert property ( // [RL5]
      $fell(en_ff) && !$past(word_valid) |-> taps_ff == $past(taps_ff)
      && scan_trigger_select_ff == $past(scan_trigger_select_ff)
      && cur_addr_ff == $past(cur_addr_ff) && end_addr_ff == $past(end_addr_ff))
      else $error("disable changed other contents");

   a_fetch_needs_go: assert property ( // [RL6]
      $rose(o_flash_rd_req) |-> $past(go_eff) && $past(i_crc_ready))
      else $error("flash read without go and ready");

   a_go_hw_clear: assert property ( // [RL7]
      go_hw_clear && !(wr_lane && reg_hit(awaddr_ff, OFF_CTL)) |=> !go_ff)
      else $error("go not cleared past end");

   a_interrupt_manage_bit_masks: assert property ( // [RL8]
      en_ff && interrupt_manage_bit_ff && i_irq_active && mode_ff != MODE_PEEK && !o_flash_rd_req
      |=> !o_flash_rd_req)
      else $error("fetch during managed interrupt");

   a_busy_shown: assert property ( // [RL9]
      ar_fire && i_araddr == OFF_CTL && in_cycle |=> o_rdata[CTL_BUSY_BIT])
      else $error("busy not shown during cycle");

   a_invalid_shown: assert property ( // [RL10]
      ar_fire && i_araddr == OFF_CTL && {1'b0, cur_addr_ff} >= FLASH_WORDS
      |=> o_rdata[CTL_INVALID_BIT])
      else $error("invalid flag not shown");

   a_addr_step: assert property ( // [RL14]
      o_scan_word_valid |=> cur_addr_ff == $past(cur_addr_ff) + 16'h0001)
      else $error("current address did not step");

   a_addr_locked: assert property ( // [RL15]
      wr_lane && go_ff && !word_valid && reg_hit(awaddr_ff, OFF_CUR_LOW)
      |=> $stable(cur_addr_ff))
      else $error("current address written while go set");

   a_end_locked: assert property ( // [RL17]
      go_ff |=> end_addr_ff == $past(end_addr_ff))
      else $error("end address changed while go set");
endmodule // crcscn_regs
`default_nettype wire

// File: test/crcscn_flash_model.sv
// Program flash model answering scan reads after a settable delay
`timescale 1ns/1ps
`default_nettype none
module crcscn_flash_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   input wire logic [1:0] i_lat,
   output logic o_valid,
   output logic [15:0] o_data
);
   logic [1:0] wait_ff;
   logic [15:0] last_ff;
   // Count out the latency, then answer once per request
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_ff <= 2'h0;
         o_valid <= 1'b0;
         last_ff <= 16'h0000;
      end else begin
         o_valid <= 1'b0;
         if (i_req && !o_valid && wait_ff == i_lat) begin
            o_valid <= 1'b1;
            last_ff <= ~i_addr;
            wait_ff <= 2'h0;
         end else if (i_req && !o_valid) begin
            wait_ff <= wait_ff + 2'h1;
         end
      end
   end
   // A released bus shows the inverse of the last word
   assign o_data = o_valid ? last_ff : ~last_ff;
endmodule // crcscn_flash_model
`default_nettype wire

// File: test/crcscn_regs_tb.sv
// Self-checking bench for the CRC scanner register block
`timescale 1ns/1ps
`default_nettype none
module crcscn_regs_tb;
   import crcscn_pkg::*;
   logic i_clk = 1'b0, i_rst_n = 1'b0;
   logic [7:0] aw = 8'h00, ar = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, rdy = 1'b0, irq = 1'b0;
   logic awr, wr_r, bv, arr, rv, acc_en, req, fv, wval, stall;
   logic [1:0] br, rr, lat = 2'h0;
   logic [31:0] rdat;
   logic [7:0] acc_d, acc_seen = 8'h00;
   logic [15:0] taps, fa, fd, word, last_w = 16'h0;
   int words = 0, cyc = 0, fail_count = 0, checks_done = 0;
   // ---------------------------------------------------------------
   // Design and far side
   // ---------------------------------------------------------------
   crcscn_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_awaddr(aw), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wd), .i_wstrb(4'h1), .i_wvalid(wv), .o_wready(wr_r),
      .o_bresp(br), .o_bvalid(bv), .i_bready(bre), .i_araddr(ar), .i_arvalid(arv),
      .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rre),
      .i_crc_acc(16'h12a5), .i_crc_shift(16'h5a3c), .i_crc_ready(rdy),
      .o_acc_wr_en(acc_en), .o_acc_wr_data(acc_d), .o_poly_taps(taps), .o_scan_word(word),
      .o_scan_word_valid(wval), .o_flash_rd_req(req), .o_flash_addr(fa),
      .i_flash_rd_valid(fv), .i_flash_rd_data(fd), .i_irq_active(irq),
      .i_peek_slot(1'b0), .i_trig_src(10'h000), .o_cpu_stall(stall));
   crcscn_flash_model flash (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_addr(fa),
      .i_lat(lat), .o_valid(fv), .o_data(fd));
   // Clock
   always #2.5 i_clk = ~i_clk;
   // Watch the CRC side and cut a hang short
   always @(posedge i_clk) begin
      if (acc_en === 1'b1) acc_seen <= acc_d;
      if (wval === 1'b1) begin
         words <= words + 1;
         last_w <= word;
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      aw <= a; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
      do begin
         @(posedge i_clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr_r === 1'b1) wv <= 1'b0;
      end while (bv !== 1'b1);
      bre <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge i_clk);
      ar <= a; arv <= 1'b1; rre <= 1'b1;
      do begin
         @(posedge i_clk);
         if (arr === 1'b1) arv <= 1'b0;
      end while (rv !== 1'b1);
      d = rdat[7:0]; r = rr; rre <= 1'b0;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      logic [1:0] r;
      rd(a, v, r);
      chk(v, e);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      rchk(OFF_ACC_LOW, 8'ha5);
      wr(OFF_ACC_LOW, 8'h3c);
      // Let the watcher's capture of the write bus settle
      @(negedge i_clk);
      chk(acc_seen, 8'h3c);
      wr(OFF_SHIFT_LOW, 8'hff);
      rchk(OFF_SHIFT_LOW, 8'h3c);
      rchk(OFF_SHIFT_HIGH, 8'h5a);
      rchk(OFF_TAPS_LOW, 8'h01);
      wr(OFF_TAPS_LOW, 8'hfe);
      wr(OFF_TAPS_HIGH, 8'h81);
      chk(taps, 16'h81ff);
      rchk(OFF_CUR_LOW, 8'h00);
      wr(OFF_CTL, 8'h0b);
      rchk(OFF_CTL, 8'h0b);
   endtask
   task automatic t_guard;
      wr(OFF_END_LOW, 8'h02);
      wr(OFF_CTL, 8'hc0);
      wr(OFF_CUR_LOW, 8'h55);
      wr(OFF_END_LOW, 8'h09);
      rchk(OFF_CUR_LOW, 8'h00);
      rchk(OFF_END_LOW, 8'h02);
      chk(words, 0);
      wr(OFF_CTL, 8'h40);
      rchk(OFF_CTL, 8'h40);
      rchk(OFF_END_LOW, 8'h02);
   endtask
   task automatic t_scan;
      logic [7:0] v;
      logic [1:0] r;
      rdy <= 1'b1;
      lat <= 2'h3;
      wr(OFF_CTL, 8'hc0);
      v = 8'h40;
      for (int k = 0; k < 60 && v[6]; k++) rd(OFF_CTL, v, r);
      chk(words, 3);
      chk(last_w, 16'hfffd);
      rchk(OFF_CUR_LOW, 8'h03);
      rchk(OFF_CTL, 8'ha0);
   endtask
   // Managed interrupt in burst mode holds the scan, release lets it finish
   task automatic t_irq;
      irq <= 1'b1;
      wr(OFF_END_LOW, 8'h04);
      wr(OFF_CTL, 8'hc9);
      repeat (20) @(posedge i_clk);
      chk(words, 3);
      chk(stall, 1'b0);
      rchk(OFF_CTL, 8'he9);
      irq <= 1'b0;
      @(posedge i_clk);
      chk(stall, 1'b1);
      repeat (40) @(posedge i_clk);
      chk(words, 5);
      chk(stall, 1'b0);
   endtask
   task automatic t_misc;
      logic [7:0] v;
      logic [1:0] r;
      wr(OFF_CTL, 8'h00);
      wr(OFF_CUR_HIGH, 8'h40);
      rchk(OFF_CTL, 8'h10);
      rd(8'h2c, v, r);
      chk(r, RESP_SLVERR);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_guard();
      t_scan();
      t_irq();
      t_misc();
      close_out();
   end
endmodule // crcscn_regs_tb
`default_nettype wire
